/* File: core/sds_cfg.svh */
/*
 Constants of the 14-bit serdes pair: slice width, slot counts and
 reset values. Assumes it is included by bare name, once or more.
*/
`ifndef SDS_CFG_SVH
`define SDS_CFG_SVH

`define SDS_SLICE_BITS     7
`define SDS_SLOT_BITS      3
`define SDS_LAST_SLOT      3'h6
`define SDS_SLOT_LATE      3'h7
`define SDS_FWD_HIGH_SLOTS 3'h4
`define SDS_OUT_FALL_SLOT  3'h3
`define SDS_LOCK_FRAMES    3'h4
`define SDS_SLICE_RST      7'h00
`define SDS_SLOT_RST       3'h0

`endif

/* File: core/sds_lane_tx.sv */
/*
 One serial transmit lane: loads a slice and shifts it out bit 0 first.
 Assumes load comes once per slice period from the caller's slot counter.
*/
`include "sds_cfg.svh"

module sds_lane_tx #(
   parameter int W = `SDS_SLICE_BITS
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic         clr,
   input  wire logic [W-1:0] par,
   output logic              ser
);
   logic [W-1:0] sh_r;

   // shifter keeps running while cleared so slot alignment is never lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_r <= '0;
         ser  <= 1'b0;
      end else begin
         sh_r <= load ? (par >> 1) : (sh_r >> 1);
         ser  <= clr ? 1'b0 : (load ? par[0] : sh_r[0]);
      end
   end
endmodule // sds_lane_tx

/* File: core/sds_pkg.sv */
/*
 Types shared by the serdes pair modules.
 Assumes sds_cfg.svh is on the include path.
*/
`include "sds_cfg.svh"

package sds_pkg;
   typedef logic [`SDS_SLICE_BITS-1:0] sds_slice_type;
   typedef logic [`SDS_SLOT_BITS-1:0]  sds_slot_type;
   typedef enum logic [1:0] {SDS_HUNT, SDS_TRACK, SDS_LOCKED} sds_rx_state_type;
endpackage

/* File: core/sds_serdes_pair.sv */
/*
 Full-duplex 14-bit serdes pair. Transmit side runs on ref_clk, which is
 the bit clock: the host's parallel clock must run at ref_clk/7. Receive
 side runs on link_bit_clk, the bit clock of the incoming link, at seven
 times the received lane clock. All pins pass two flops first, except rst_n on the ref_clk side.
*/
`include "sds_cfg.svh"

module sds_serdes_pair
   import sds_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   tx_par_clk,
   input  wire logic                   tx_edge_rising_sel,
   input  wire logic                   tx_enable,
   input  wire sds_pkg::sds_slice_type first_lane_parallel_in,
   input  wire sds_pkg::sds_slice_type second_lane_parallel_in,
   output logic                        first_serial_lane_out,
   output logic                        first_serial_lane_out_oe,
   output logic                        second_serial_lane_out,
   output logic                        second_serial_lane_out_oe,
   output logic                        forwarded_lane_clock_out,
   output logic                        forwarded_lane_clock_out_oe,
   input  wire logic                   link_bit_clk,
   input  wire logic                   rx_lane_clk,
   input  wire logic                   first_serial_lane_in,
   input  wire logic                   second_serial_lane_in,
   input  wire logic                   rx_enable,
   output sds_pkg::sds_slice_type      first_lane_parallel_out,
   output sds_pkg::sds_slice_type      second_lane_parallel_out,
   output logic                        rx_par_clk_out
);
   import sds_pkg::*;

   // transmit side, ref_clk domain
   logic          tx_clk_s;
   logic          tx_clk_d;
   logic          tx_sel_s;
   logic          tx_en_s;
   sds_slice_type tx_a_s;
   sds_slice_type tx_b_s;
   sds_slice_type hold_a_r;
   sds_slice_type hold_b_r;
   sds_slot_type  tx_slot_r;
   sds_slot_type  tx_slot_nxt;
   logic          tx_rise;
   logic          tx_fall;
   logic          tx_cap;
   logic          tx_load;

   // receive side, link_bit_clk domain
   logic             link_rst_n;
   logic             rx_clk_s;
   logic             rx_clk_d;
   logic             rx_a_s;
   logic             rx_b_s;
   logic             rx_en_s;
   logic             rx_rise;
   logic             rx_good;
   logic             rx_late;
   sds_slice_type    sh_a_r;
   sds_slice_type    sh_b_r;
   sds_slot_type     rx_slot_r;
   sds_slot_type     good_r;
   sds_rx_state_type rx_state_r;

   // pins into ref_clk: clock, select, enable and data share one depth
   sds_sync2 #(
      .W (3 + 2 * `SDS_SLICE_BITS)
   ) u_tx_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({tx_par_clk, tx_edge_rising_sel, tx_enable,
               first_lane_parallel_in, second_lane_parallel_in}),
      .q     ({tx_clk_s, tx_sel_s, tx_en_s, tx_a_s, tx_b_s})
   );

   // edge history of the synchronised parallel clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_clk_d <= 1'b0;
      end else begin
         tx_clk_d <= tx_clk_s;
      end
   end

   // capture edge chosen by the select level
   assign tx_rise = tx_clk_s & ~tx_clk_d;
   assign tx_fall = ~tx_clk_s & tx_clk_d;
   assign tx_cap  = tx_sel_s ? tx_rise : tx_fall;

   // holding registers take the whole word at once
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_a_r <= `SDS_SLICE_RST;
         hold_b_r <= `SDS_SLICE_RST;
      end else if (tx_cap) begin
         hold_a_r <= tx_a_s;
         hold_b_r <= tx_b_s;
      end
   end

   // slot counter restarts on each capture, so it tracks the input clock
   always_comb begin
      if (tx_cap) begin
         tx_slot_nxt = `SDS_SLOT_RST;
      end else if (tx_slot_r == `SDS_LAST_SLOT) begin
         tx_slot_nxt = `SDS_SLOT_RST;
      end else begin
         tx_slot_nxt = tx_slot_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_slot_r <= `SDS_SLOT_RST;
      end else begin
         tx_slot_r <= tx_slot_nxt;
      end
   end

   // a missing capture edge repeats the held word rather than stalling
   assign tx_load = tx_cap | (tx_slot_r == `SDS_LAST_SLOT);

   sds_lane_tx #(
      .W (`SDS_SLICE_BITS)
   ) u_lane_a (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .load  (tx_load),
      .clr   (~tx_en_s),
      .par   (tx_cap ? tx_a_s : hold_a_r),
      .ser   (first_serial_lane_out)
   );

   sds_lane_tx #(
      .W (`SDS_SLICE_BITS)
   ) u_lane_b (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .load  (tx_load),
      .clr   (~tx_en_s),
      .par   (tx_cap ? tx_b_s : hold_b_r),
      .ser   (second_serial_lane_out)
   );

   // forwarded clock high in slots 0..3; its rise marks bit zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         forwarded_lane_clock_out <= 1'b0;
      end else begin
         forwarded_lane_clock_out <= tx_en_s && (tx_slot_nxt < `SDS_FWD_HIGH_SLOTS);
      end
   end

   // output enables follow only the transmit enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_serial_lane_out_oe    <= 1'b0;
         second_serial_lane_out_oe   <= 1'b0;
         forwarded_lane_clock_out_oe <= 1'b0;
      end else begin
         first_serial_lane_out_oe    <= tx_en_s;
         second_serial_lane_out_oe   <= tx_en_s;
         forwarded_lane_clock_out_oe <= tx_en_s;
      end
   end

   // reset release synchronised to the link clock
   sds_sync2 #(
      .W (1)
   ) u_link_rst (
      .clk   (link_bit_clk),
      .rst_n (rst_n),
      .d     (1'b1),
      .q     (link_rst_n)
   );

   // link pins: lane clock and data share one depth, so alignment holds
   sds_sync2 #(
      .W (4)
   ) u_rx_sync (
      .clk   (link_bit_clk),
      .rst_n (link_rst_n),
      .d     ({rx_lane_clk, first_serial_lane_in, second_serial_lane_in, rx_enable}),
      .q     ({rx_clk_s, rx_a_s, rx_b_s, rx_en_s})
   );

   // lane shifters fill from the top, so bit zero ends at index 0
   always_ff @(posedge link_bit_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_clk_d <= 1'b0;
         sh_a_r   <= `SDS_SLICE_RST;
         sh_b_r   <= `SDS_SLICE_RST;
      end else begin
         rx_clk_d <= rx_clk_s;
         sh_a_r   <= {rx_a_s, sh_a_r[`SDS_SLICE_BITS-1:1]};
         sh_b_r   <= {rx_b_s, sh_b_r[`SDS_SLICE_BITS-1:1]};
      end
   end

   assign rx_rise = rx_clk_s & ~rx_clk_d;
   assign rx_good = rx_rise && (rx_slot_r == `SDS_LAST_SLOT);
   assign rx_late = (rx_slot_r == `SDS_SLOT_LATE);

   // bit slots since the last lane clock rise, saturating when overdue
   always_ff @(posedge link_bit_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_slot_r <= `SDS_SLOT_LATE;
      end else if (rx_rise) begin
         rx_slot_r <= `SDS_SLOT_RST;
      end else if (!rx_late) begin
         rx_slot_r <= rx_slot_r + 3'h1;
      end
   end

   // lock needs several frames of exactly seven bits in a row
   always_ff @(posedge link_bit_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_state_r <= SDS_HUNT;
         good_r     <= `SDS_SLOT_RST;
      end else begin
         unique case (rx_state_r)
            SDS_HUNT: begin
               if (rx_rise) begin
                  rx_state_r <= SDS_TRACK;
                  good_r     <= `SDS_SLOT_RST;
               end
            end
            SDS_TRACK: begin
               if (rx_late) begin
                  rx_state_r <= SDS_HUNT;
               end else if (rx_good) begin
                  good_r <= good_r + 3'h1;
                  if (good_r == `SDS_LOCK_FRAMES - 3'h1) begin
                     rx_state_r <= SDS_LOCKED;
                  end
               end else if (rx_rise) begin
                  good_r <= `SDS_SLOT_RST;
               end
            end
            SDS_LOCKED: begin
               if (rx_late || (rx_rise && !rx_good)) begin
                  rx_state_r <= SDS_HUNT;
               end
            end
            default: rx_state_r <= SDS_HUNT; // unused code falls back to hunting
         endcase
      end
   end

   // word and clock: clock rises with the new word and falls mid-frame
   always_ff @(posedge link_bit_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         first_lane_parallel_out  <= `SDS_SLICE_RST;
         second_lane_parallel_out <= `SDS_SLICE_RST;
         rx_par_clk_out           <= 1'b0;
      end else if (!rx_en_s || rx_state_r != SDS_LOCKED) begin
         first_lane_parallel_out  <= `SDS_SLICE_RST;
         second_lane_parallel_out <= `SDS_SLICE_RST;
         rx_par_clk_out           <= 1'b0;
      end else if (rx_good) begin
         first_lane_parallel_out  <= sh_a_r;
         second_lane_parallel_out <= sh_b_r;
         rx_par_clk_out           <= 1'b1;
      end else if (rx_slot_r == `SDS_OUT_FALL_SLOT) begin
         rx_par_clk_out <= 1'b0;
      end
   end

   // checks on the transmit side
   a_tx_first_bit: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      tx_cap && tx_en_s |=> first_serial_lane_out == hold_a_r[0])
      else $error("first lane did not send bit zero first");

   a_tx_last_bit: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (tx_cap && tx_en_s) ##1 (!tx_cap && tx_en_s) [*6]
      |=> second_serial_lane_out == hold_b_r[6])
      else $error("second lane bit six not in slot six");

   a_edge_capture: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(tx_clk_s) && tx_sel_s |=> hold_a_r == $past(tx_a_s) && hold_b_r == $past(tx_b_s))
      else $error("rising edge select did not capture the word");

   a_edge_ignored: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(tx_clk_s) && tx_sel_s |=> hold_a_r == $past(hold_a_r))
      else $error("falling edge captured while rising selected");

   a_fwd_clk_phase: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (tx_cap && tx_en_s) ##1 (!tx_cap && tx_en_s) [*4]
      |=> !forwarded_lane_clock_out && $past(forwarded_lane_clock_out, 2))
      else $error("forwarded clock not high for slots 0 to 3");

   a_tx_hiz: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !tx_en_s |=> !first_serial_lane_out_oe && !second_serial_lane_out_oe
                   && !forwarded_lane_clock_out_oe && !forwarded_lane_clock_out)
      else $error("serial outputs driven while transmit disabled");

   // checks on the receive side
   a_rx_word_load: assert property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      rx_good && rx_en_s && rx_state_r == SDS_LOCKED
      |=> first_lane_parallel_out == $past(sh_a_r) && rx_par_clk_out)
      else $error("word not presented on a good lane clock rise");

   a_rx_bit_zero: assert property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      rx_good && rx_en_s && rx_state_r == SDS_LOCKED
      |=> second_lane_parallel_out[0] == $past(rx_b_s, 8))
      else $error("bit zero not taken from the slot at the clock rise");

   a_rx_fall_stable: assert property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      $fell(rx_par_clk_out) && rx_state_r == SDS_LOCKED && rx_en_s
      |-> $stable(first_lane_parallel_out) && $stable(second_lane_parallel_out))
      else $error("word changed at output clock fall");

   a_rx_off_low: assert property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      !rx_en_s |=> first_lane_parallel_out == 7'h00
                   && second_lane_parallel_out == 7'h00 && !rx_par_clk_out)
      else $error("receive outputs not low while disabled");

   a_rx_unlock_low: assert property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      rx_rise && !rx_good |=> rx_state_r != SDS_LOCKED ##1 !rx_par_clk_out)
      else $error("bad frame did not drop lock");

   c_tx_frame: cover property (
      @(posedge ref_clk) disable iff (!rst_n)
      (tx_cap && tx_en_s) ##7 (tx_cap && tx_en_s));

   c_tx_disable: cover property (
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(tx_en_s));

   c_rx_lock: cover property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      rx_state_r == SDS_TRACK ##1 rx_state_r == SDS_LOCKED);

   c_rx_word: cover property (
      @(posedge link_bit_clk) disable iff (!link_rst_n)
      $rose(rx_par_clk_out) ##4 $fell(rx_par_clk_out));
endmodule // sds_serdes_pair

/* File: core/sds_sync2.sv */
/*
 Two-flop level synchroniser, W bits wide.
 Assumes each bit is a slow level or is sampled with equal delay to its peers.
*/
module sds_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first flop feeds only the second one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sds_sync2

/* File: verification/sds_far_ser.sv */
/*
 Far-end serializer model feeding the receive link of the serdes pair.
 Assumes words are held for whole frames; run low idles the link.
*/
module sds_far_ser
   import sds_pkg::*;
(
   input  wire logic                   link_bit_clk,
   input  wire logic                   run,
   input  wire logic                   short_frame,
   input  wire sds_pkg::sds_slice_type word_a,
   input  wire sds_pkg::sds_slice_type word_b,
   output logic                        rx_lane_clk,
   output logic                        lane_a,
   output logic                        lane_b
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [2:0]    slot_r = 3'h0;
   logic          clk_r  = 1'b0;
   logic          a_r    = 1'b0;
   logic          b_r    = 1'b1;
   sds_slice_type hold_a_r;
   sds_slice_type hold_b_r;

   // idle link: clock stands still, data toggles so a stale bit never looks valid
   // lanes move on the falling edge, half a bit before the receiver samples
   always @(negedge link_bit_clk) begin
      if (!run) begin
         slot_r <= 3'h0;
         clk_r  <= 1'b0;
         a_r    <= ~a_r;
         b_r    <= ~b_r;
      end else begin
         clk_r <= (slot_r < 3'h4);
         a_r   <= (slot_r == 3'h0) ? word_a[0] : hold_a_r[slot_r];
         b_r   <= (slot_r == 3'h0) ? word_b[0] : hold_b_r[slot_r];
         if (slot_r == 3'h0) begin
            hold_a_r <= word_a;
            hold_b_r <= word_b;
         end
         // a short frame is a deliberate framing fault commanded by the bench
         // compare with >= so a fault raised in the last slot never runs past bit six
         slot_r <= (slot_r >= (short_frame ? 3'h5 : 3'h6)) ? 3'h0 : slot_r + 3'h1;
      end
   end

   assign rx_lane_clk = clk_r;
   assign lane_a      = a_r;
   assign lane_b      = b_r;
endmodule // sds_far_ser

/* File: verification/testbench.sv */
/*
 Self-checking bench of the serdes pair: host clock at ref_clk/7, far-end
 serializer model on the link. Assumes the design package is compiled first.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import sds_pkg::*;

   logic          ref_clk = 1'b0;
   logic          link_bit_clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          tx_par_clk = 1'b0;
   logic          tx_edge_rising_sel = 1'b1;
   logic          tx_enable = 1'b1;
   logic          rx_enable = 1'b1;
   sds_slice_type tx_a = 7'h00;
   sds_slice_type tx_b = 7'h00;
   sds_slice_type rise_a, rise_b, fall_a, fall_b, far_a, far_b;
   logic          far_run = 1'b0;
   logic          far_short = 1'b0;
   logic [2:0]    ph = 3'h0;
   logic          fa, fa_oe, fb, fb_oe, fc, fc_oe, rx_clk, ln_a, ln_b, rx_par_clk_out;
   sds_slice_type out_a, out_b;
   wire           fa_w = fa_oe ? fa : 1'bz;
   wire           fb_w = fb_oe ? fb : 1'bz;
   wire           fc_w = fc_oe ? fc : 1'bz;
   int            err_count = 0;
   int            n_tests = 0;

   always #25 ref_clk = ~ref_clk;
   // link clock offset so its edges never line up with ref_clk
   initial begin
      #7.3;
      forever #62.5 link_bit_clk = ~link_bit_clk;
   end

   // host: rising-edge word around the rise, falling-edge word around the fall
   always @(negedge ref_clk) begin
      ph         <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
      tx_par_clk <= (ph < 3'h4);
      tx_a       <= (ph >= 3'h2 && ph <= 3'h5) ? fall_a : rise_a;
      tx_b       <= (ph >= 3'h2 && ph <= 3'h5) ? fall_b : rise_b;
   end

   sds_serdes_pair sds_serdes_pair_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .tx_par_clk(tx_par_clk),
      .tx_edge_rising_sel(tx_edge_rising_sel), .tx_enable(tx_enable),
      .first_lane_parallel_in(tx_a), .second_lane_parallel_in(tx_b),
      .first_serial_lane_out(fa), .first_serial_lane_out_oe(fa_oe),
      .second_serial_lane_out(fb), .second_serial_lane_out_oe(fb_oe),
      .forwarded_lane_clock_out(fc), .forwarded_lane_clock_out_oe(fc_oe),
      .link_bit_clk(link_bit_clk), .rx_lane_clk(rx_clk),
      .first_serial_lane_in(ln_a), .second_serial_lane_in(ln_b), .rx_enable(rx_enable),
      .first_lane_parallel_out(out_a), .second_lane_parallel_out(out_b),
      .rx_par_clk_out(rx_par_clk_out));

   sds_far_ser sds_far_ser_i (
      .link_bit_clk(link_bit_clk), .run(far_run), .short_frame(far_short),
      .word_a(far_a), .word_b(far_b), .rx_lane_clk(rx_clk), .lane_a(ln_a), .lane_b(ln_b));

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [13:0] seen, input logic [13:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // align on a rise of the forwarded clock, then collect one slice per lane
   task automatic tx_frame(input sds_slice_type a, input sds_slice_type b);
      logic [6:0] sa, sb, fk;
      logic       p;
      int         k;
      k = 0;
      do begin
         p = fc_w;
         @(negedge ref_clk);
         k++;
      end while (!(p === 1'b0 && fc_w === 1'b1) && k < 20);
      for (int i = 0; i < 7; i++) begin
         sa[i] = fa_w;
         sb[i] = fb_w;
         fk[i] = fc_w;
         @(negedge ref_clk);
      end
      check({sb, sa}, {b, a});
      check({7'h00, fk}, 14'h000F);
   endtask

   // wait for a fall of the output clock, take the word, time one period
   task automatic rx_check(input sds_slice_type a, input sds_slice_type b);
      logic p;
      int   n;
      for (int j = 0; j < 2; j++) begin
         n = 0;
         do begin
            p = rx_par_clk_out;
            @(negedge link_bit_clk);
            n++;
         end while (!(p === 1'b1 && rx_par_clk_out === 1'b0) && n < 30);
         if (j == 0)
            check({out_b, out_a}, {b, a});
      end
      check(14'(n), 14'h0007);
   endtask

   // outputs must stay low for the whole span
   task automatic rx_quiet(input int n);
      logic [13:0] acc;
      acc = 14'h0000;
      repeat (n) begin
         @(negedge link_bit_clk);
         acc = acc | {out_b, out_a} | {13'h0000, rx_par_clk_out};
      end
      check(acc, 14'h0000);
   endtask

   task automatic t_tx_edges();
      {rise_a, rise_b, fall_a, fall_b} = {7'h35, 7'h4A, 7'h0B, 7'h71};
      for (int s = 1; s >= 0; s--) begin
         @(negedge ref_clk);
         tx_edge_rising_sel = s[0];
         repeat (21) @(negedge ref_clk);
         tx_frame(s ? rise_a : fall_a, s ? rise_b : fall_b);
         tx_frame(s ? rise_a : fall_a, s ? rise_b : fall_b);
      end
   endtask

   task automatic t_rx_words();
      sds_slice_type wa[3] = '{7'h7F, 7'h01, 7'h55};
      sds_slice_type wb[3] = '{7'h00, 7'h40, 7'h2A};
      far_a = wa[0];
      far_b = wb[0];
      far_run = 1'b1;
      rx_quiet(26);
      for (int i = 0; i < 3; i++) begin
         // non-blocking: the model latches words on this very edge
         far_a <= wa[i];
         far_b <= wb[i];
         repeat (21) @(negedge link_bit_clk);
         rx_check(wa[i], wb[i]);
      end
   endtask

   // transmit off while receive keeps running
   task automatic t_tx_disable();
      @(negedge ref_clk);
      tx_enable = 1'b0;
      repeat (5) @(negedge ref_clk);
      check({11'h000, fa_w, fb_w, fc_w}, {11'h000, 3'bzzz});
      rx_check(far_a, far_b);
      @(negedge ref_clk);
      tx_enable = 1'b1;
      repeat (21) @(negedge ref_clk);
      tx_frame(fall_a, fall_b);
   endtask

   // receive off while transmit keeps running
   task automatic t_rx_disable();
      @(negedge ref_clk);
      rx_enable = 1'b0;
      repeat (4) @(negedge link_bit_clk);
      rx_quiet(10);
      tx_frame(fall_a, fall_b);
      @(negedge ref_clk);
      rx_enable = 1'b1;
      repeat (40) @(negedge link_bit_clk);
      rx_check(far_a, far_b);
   endtask

   // a framing fault must drop lock and blank the outputs until relocked
   task automatic t_rx_short();
      far_short <= 1'b1;
      repeat (14) @(negedge link_bit_clk);
      far_short <= 1'b0;
      repeat (4) @(negedge link_bit_clk);
      rx_quiet(20);
      repeat (25) @(negedge link_bit_clk);
      rx_check(far_a, far_b);
   endtask

   initial begin
      {rise_a, rise_b, fall_a, fall_b, far_a, far_b} = '0;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      t_tx_edges();
      t_rx_words();
      t_tx_disable();
      t_rx_disable();
      t_rx_short();
      report_and_stop();
   end

   // watchdog: the sequence needs a little over a tenth of this span
   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end
endmodule // testbench
